// ==== pkg/axis_ref_pkg.sv ====
// Purpose: constants and types for the six-axis reference search block
// Assumes: 100 MHz clock; command frames arrive one byte per strobe
// Notes: positions are counted in microsteps; registers sit on APB
package axis_ref_pkg;
    localparam int AXES = 6;
    localparam logic [3:0] LAST_BYTE = 4'h8;
    localparam logic [7:0] CMD_SET_PARAMS = 8'h15;
    localparam logic [7:0] CMD_BEGIN_HOMING = 8'h23;
    localparam int B_ADDR = 0;
    localparam int B_CMD = 1;
    localparam int B_AXIS = 2;
    localparam int B_LEN0 = 3;
    localparam int B_LEN1 = 4;
    localparam int B_LEN2 = 5;
    localparam int B_P5 = 7;
    localparam int F_LEFT = 4;
    localparam int F_STOPREF = 6;
    localparam int F_POL = 6;
    localparam int F_MECH = 2;
    localparam int USTEP_SHIFT = 4;
    localparam int CLK_NS = 10;
    localparam int STEP_NS = 1000;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_MASK = 12'h004;
    localparam logic [11:0] ADDR_ROTATE = 12'h008;
    localparam logic [11:0] ADDR_STATE = 12'h00c;
    localparam logic [11:0] ADDR_POS = 12'h010;
    localparam logic [11:0] ADDR_FULL = 12'h030;
    localparam int STATE_REF_LSB = 8;
    localparam logic [6:0] SEG_8 = 7'h7f;
    localparam logic [6:0] SEG_C = 7'h39;
    localparam logic [6:0] SEG_F = 7'h71;
    localparam logic [6:0] SEG_0 = 7'h3f;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic {SEARCH_IDLE = 1'b0, SEARCH_RUN = 1'b1} search_st_t;

    typedef struct packed {
        search_st_t st;
        logic left;
        logic pol;
        logic stopref;
        logic mech;
        logic rot;
        logic referenced;
        logic step;
        logic dir;
        logic [23:0] lim;
        logic [23:0] pos;
        logic [25:0] travel;
        logic [15:0] timer;
    } axis_t;

    typedef struct packed {
        axis_t [AXES-1:0] ax;
        logic [3:0] cnt;
        logic [7:0][7:0] fbuf;
        logic [2*AXES-1:0] status;
        logic [2*AXES-1:0] mask;
        apb_rsp_t rsp;
        logic irq;
        logic [6:0] seg;
        logic dp;
        logic [AXES-1:0] decay;
    } state_t;
endpackage

// ==== rtl/axis_reference_search.sv ====
// Purpose: per-axis reference search, end switches and indicator
// Assumes: inputs synchronous to clock_in; one APB wait state
// Notes: one step pulse per step period while a search runs and drv_enable_in is high
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module axis_reference_search #(
    parameter int STEP_CYCLES = axis_ref_pkg::STEP_CYC
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire axis_ref_pkg::apb_req_t apb_in,
    output axis_ref_pkg::apb_rsp_t apb_out,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_valid_in,
    input wire logic rx_break_in,
    input wire logic [7:0] unit_addr_in,
    input wire logic [axis_ref_pkg::AXES-1:0] ref_in,
    input wire logic [axis_ref_pkg::AXES-1:0] stop_left_in,
    input wire logic [axis_ref_pkg::AXES-1:0] stop_right_in,
    input wire logic drv_enable_in,
    input wire logic decay_off_odd_group_in,
    input wire logic decay_off_even_group_in,
    input wire logic [1:0] fault_code_in,
    output logic [axis_ref_pkg::AXES-1:0] step_out,
    output logic [axis_ref_pkg::AXES-1:0] dir_out,
    output logic [axis_ref_pkg::AXES-1:0] mixed_decay_out,
    output logic [6:0] seg_out,
    output logic seg_dp_out,
    output logic irq_out
);
    localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

    axis_ref_pkg::state_t q;
    axis_ref_pkg::state_t n;
    logic frame_done;
    logic apb_first;
    logic apb_last;

    // ==========================================================
    // decode helpers
    function automatic logic [3:0] slot(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        if (a >= base && off < 12'(4 * axis_ref_pkg::AXES) && off[1:0] == 2'b00) begin
            return off[5:2];
        end
        return 4'hf;
    endfunction

    function automatic logic [6:0] seg_digit(input logic [3:0] d);
        unique case (d)
            4'h0: return axis_ref_pkg::SEG_0;
            4'h1: return 7'h06;
            4'h2: return 7'h5b;
            4'h3: return 7'h4f;
            4'h4: return 7'h66;
            4'h5: return 7'h6d;
            4'h6: return 7'h7d;
            default: return axis_ref_pkg::SEG_8;
        endcase
    endfunction

    // returns {slave error, read data}
    function automatic logic [32:0] read_word(input axis_ref_pkg::state_t s, input logic [11:0] a);
        logic [31:0] d;
        logic [3:0] ps;
        logic [3:0] fs;
        d = '0;
        ps = slot(a, axis_ref_pkg::ADDR_POS);
        fs = slot(a, axis_ref_pkg::ADDR_FULL);
        if (a == axis_ref_pkg::ADDR_STATUS) begin
            d[2*axis_ref_pkg::AXES-1:0] = s.status;
        end else if (a == axis_ref_pkg::ADDR_MASK) begin
            d[2*axis_ref_pkg::AXES-1:0] = s.mask;
        end else if (a == axis_ref_pkg::ADDR_ROTATE) begin
            for (int i = 0; i < axis_ref_pkg::AXES; i++) begin
                d[i] = s.ax[i].rot;
            end
        end else if (a == axis_ref_pkg::ADDR_STATE) begin
            for (int i = 0; i < axis_ref_pkg::AXES; i++) begin
                d[i] = (s.ax[i].st == axis_ref_pkg::SEARCH_RUN);
                d[axis_ref_pkg::STATE_REF_LSB + i] = s.ax[i].referenced;
            end
        end else if (ps != 4'hf) begin
            d[23:0] = s.ax[ps].pos;
        end else if (fs != 4'hf) begin
            d[23:0] = s.ax[fs].pos >> axis_ref_pkg::USTEP_SHIFT;
        end else begin
            return {1'b1, 32'h0000_0000};
        end
        return {1'b0, d};
    endfunction

    assign frame_done = rx_valid_in && !rx_break_in && q.cnt == axis_ref_pkg::LAST_BYTE
                        && q.fbuf[axis_ref_pkg::B_ADDR] == unit_addr_in;
    assign apb_first = apb_in.psel && apb_in.penable && !q.rsp.pready;
    assign apb_last = apb_in.psel && apb_in.penable && q.rsp.pready;

    // ==========================================================
    // next state
    always_comb begin
        logic ract;
        logic lstop;
        logic blk;
        logic fin;
        logic [3:0] act;
        logic [32:0] rd;
        ract = 1'b0;
        lstop = 1'b0;
        blk = 1'b0;
        fin = 1'b0;
        act = 4'h0;
        rd = read_word(q, apb_in.paddr);
        n = q;
        n.rsp.pready = 1'b0;
        n.rsp.pslverr = 1'b0;

        // bus: answer one cycle after the access phase starts
        if (apb_first) begin
            n.rsp.pready = 1'b1;
            n.rsp.pslverr = rd[32];
            n.rsp.prdata = rd[31:0];
        end
        if (apb_last && apb_in.pwrite && !q.rsp.pslverr) begin
            if (apb_in.paddr == axis_ref_pkg::ADDR_MASK) begin
                n.mask = apb_in.pwdata[2*axis_ref_pkg::AXES-1:0];
            end
            if (apb_in.paddr == axis_ref_pkg::ADDR_ROTATE) begin
                for (int i = 0; i < axis_ref_pkg::AXES; i++) begin
                    n.ax[i].rot = apb_in.pwdata[i];
                end
            end
        end
        // clear only what the read returned; events after it survive
        if (apb_last && !apb_in.pwrite && apb_in.paddr == axis_ref_pkg::ADDR_STATUS) begin
            n.status = q.status & ~q.rsp.prdata[2*axis_ref_pkg::AXES-1:0];
        end

        // frame assembly; a break throws away a partial frame
        if (rx_break_in) begin
            n.cnt = 4'h0;
        end else if (rx_valid_in) begin
            if (q.cnt == axis_ref_pkg::LAST_BYTE) begin
                n.cnt = 4'h0;
            end else begin
                n.fbuf[q.cnt[2:0]] = rx_byte_in;
                n.cnt = q.cnt + 4'h1;
            end
        end

        for (int i = 0; i < axis_ref_pkg::AXES; i++) begin
            n.ax[i].step = 1'b0;
            ract = ref_in[i] ^ q.ax[i].pol;
            lstop = stop_left_in[i] | (q.ax[i].stopref & ract);
            blk = q.ax[i].left ? lstop : stop_right_in[i];
            fin = q.ax[i].mech ? (q.ax[i].travel == 26'h000_0000) : ract;
            unique case (q.ax[i].st)
                axis_ref_pkg::SEARCH_IDLE: begin
                    if (frame_done && q.fbuf[axis_ref_pkg::B_AXIS] == 8'(i)) begin
                        if (q.fbuf[axis_ref_pkg::B_CMD] == axis_ref_pkg::CMD_SET_PARAMS) begin
                            n.ax[i].lim = {q.fbuf[axis_ref_pkg::B_LEN2], q.fbuf[axis_ref_pkg::B_LEN1],
                                           q.fbuf[axis_ref_pkg::B_LEN0]};
                            n.ax[i].left = q.fbuf[axis_ref_pkg::B_P5][axis_ref_pkg::F_LEFT];
                            n.ax[i].stopref = q.fbuf[axis_ref_pkg::B_P5][axis_ref_pkg::F_STOPREF];
                            n.ax[i].pol = rx_byte_in[axis_ref_pkg::F_POL];
                            n.ax[i].mech = rx_byte_in[axis_ref_pkg::F_MECH];
                        end else if (q.fbuf[axis_ref_pkg::B_CMD] == axis_ref_pkg::CMD_BEGIN_HOMING) begin
                            n.ax[i].st = axis_ref_pkg::SEARCH_RUN;
                            n.ax[i].referenced = 1'b0;
                            n.ax[i].timer = 16'h0000;
                            n.ax[i].dir = !q.ax[i].left;
                            n.ax[i].travel = {2'b00, q.ax[i].lim} + {4'h0, q.ax[i].lim[23:2]};
                        end
                    end
                end
                axis_ref_pkg::SEARCH_RUN: begin
                    if (!drv_enable_in) begin
                        n.ax[i].timer = q.ax[i].timer;
                    end else if (fin) begin
                        n.ax[i].st = axis_ref_pkg::SEARCH_IDLE;
                        n.ax[i].pos = 24'h00_0000;
                        n.ax[i].referenced = 1'b1;
                        n.status[i] = 1'b1;
                    end else if (blk) begin
                        n.ax[i].st = axis_ref_pkg::SEARCH_IDLE;
                        n.status[axis_ref_pkg::AXES + i] = 1'b1;
                    end else if (q.ax[i].timer == STEP_LAST) begin
                        n.ax[i].timer = 16'h0000;
                        n.ax[i].step = 1'b1;
                        n.ax[i].travel = q.ax[i].travel - 26'h000_0001;
                        if (q.ax[i].left) begin
                            if (q.ax[i].rot && q.ax[i].pos == 24'h00_0000) begin
                                n.ax[i].pos = q.ax[i].lim - 24'h00_0001;
                            end else begin
                                n.ax[i].pos = q.ax[i].pos - 24'h00_0001;
                            end
                        end else if (q.ax[i].rot && q.ax[i].pos + 24'h00_0001 >= q.ax[i].lim) begin
                            n.ax[i].pos = 24'h00_0000;
                        end else begin
                            n.ax[i].pos = q.ax[i].pos + 24'h00_0001;
                        end
                    end else begin
                        n.ax[i].timer = q.ax[i].timer + 16'h0001;
                    end
                end
            endcase
            if (q.ax[i].st == axis_ref_pkg::SEARCH_RUN) begin
                act = act + 4'h1;
            end
            n.decay[i] = (i % 2 == 0) ? !decay_off_odd_group_in : !decay_off_even_group_in;
        end

        unique case (fault_code_in)
            2'b00: n.seg = seg_digit(act);
            2'b01: n.seg = axis_ref_pkg::SEG_8;
            2'b10: n.seg = axis_ref_pkg::SEG_C;
            2'b11: n.seg = axis_ref_pkg::SEG_F;
        endcase
        n.dp = 1'b0;
        for (int i = 0; i < axis_ref_pkg::AXES; i++) begin
            n.dp = n.dp | n.ax[i].referenced;
        end
        n.irq = |(n.status & n.mask);
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q <= '0;
            q.seg <= axis_ref_pkg::SEG_0;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs
    assign apb_out = q.rsp;
    assign seg_out = q.seg;
    assign seg_dp_out = q.dp;
    assign irq_out = q.irq;
    for (genvar g = 0; g < axis_ref_pkg::AXES; g++) begin : g_out
        assign step_out[g] = q.ax[g].step;
        assign dir_out[g] = q.ax[g].dir;
        assign mixed_decay_out[g] = q.decay[g];
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_run0;
        q.ax[0].st == axis_ref_pkg::SEARCH_RUN && drv_enable_in;
    endsequence

    // the first edge after reset still shows the reset value, so skip it
    property p_decay;
        $past(arst_n_in) |-> mixed_decay_out[0] == !$past(decay_off_odd_group_in)
            && mixed_decay_out[1] == !$past(decay_off_even_group_in);
    endproperty
    a_decay: assert property (p_decay) else $error("decay select wrong");

    property p_zero;
        fault_code_in == 2'b00 && q.ax[0].st == axis_ref_pkg::SEARCH_IDLE && q.ax[1].st == axis_ref_pkg::SEARCH_IDLE
        && q.ax[2].st == axis_ref_pkg::SEARCH_IDLE && q.ax[3].st == axis_ref_pkg::SEARCH_IDLE
        && q.ax[4].st == axis_ref_pkg::SEARCH_IDLE && q.ax[5].st == axis_ref_pkg::SEARCH_IDLE
        |=> seg_out == axis_ref_pkg::SEG_0;
    endproperty
    a_zero: assert property (p_zero) else $error("idle display not zero");

    property p_fault;
        fault_code_in == 2'b10 |=> seg_out == axis_ref_pkg::SEG_C;
    endproperty
    a_fault: assert property (p_fault) else $error("fault glyph wrong");

    property p_frame;
        rx_valid_in && !rx_break_in && q.cnt == axis_ref_pkg::LAST_BYTE |=> q.cnt == 4'h0;
    endproperty
    a_frame: assert property (p_frame) else $error("frame length wrong");

    property p_wrap;
        q.ax[5].st == axis_ref_pkg::SEARCH_RUN && drv_enable_in && q.ax[5].rot && !q.ax[5].left
        && q.ax[5].timer == STEP_LAST && q.ax[5].pos == q.ax[5].lim - 24'h00_0001
        && !q.ax[5].mech && !(ref_in[5] ^ q.ax[5].pol) && !stop_right_in[5]
        |=> q.ax[5].pos == 24'h00_0000 && step_out[5];
    endproperty
    a_wrap: assert property (p_wrap) else $error("rotating wrap missed");

    property p_travel;
        q.ax[0].st == axis_ref_pkg::SEARCH_IDLE && frame_done && q.fbuf[axis_ref_pkg::B_AXIS] == 8'h00
        && q.fbuf[axis_ref_pkg::B_CMD] == axis_ref_pkg::CMD_BEGIN_HOMING
        |=> q.ax[0].st == axis_ref_pkg::SEARCH_RUN && dir_out[0] == !q.ax[0].left
            && q.ax[0].travel == {2'b00, q.ax[0].lim} + {4'h0, q.ax[0].lim[23:2]};
    endproperty
    a_travel: assert property (p_travel) else $error("search start wrong");

    property p_ref;
        s_run0 and !q.ax[0].mech && (ref_in[0] ^ q.ax[0].pol)
        |=> q.ax[0].st == axis_ref_pkg::SEARCH_IDLE && q.ax[0].referenced
            && q.ax[0].pos == 24'h00_0000 ##1 seg_dp_out;
    endproperty
    a_ref: assert property (p_ref) else $error("reference not captured");

    // axis 3 runs the combined reference and left stop switch
    property p_stop;
        q.ax[3].st == axis_ref_pkg::SEARCH_RUN && drv_enable_in && q.ax[3].left && q.ax[3].mech
        && q.ax[3].travel != 26'h000_0000
        && (stop_left_in[3] || (q.ax[3].stopref && (ref_in[3] ^ q.ax[3].pol)))
        |=> q.ax[3].st == axis_ref_pkg::SEARCH_IDLE && !step_out[3] && !q.ax[3].referenced;
    endproperty
    a_stop: assert property (p_stop) else $error("end switch ignored");

    property p_hold;
        q.ax[4].st == axis_ref_pkg::SEARCH_RUN && !drv_enable_in
        |=> $stable(q.ax[4].pos) && !step_out[4] && q.ax[4].st == axis_ref_pkg::SEARCH_RUN;
    endproperty
    a_hold: assert property (p_hold) else $error("state lost while disabled");
endmodule

// ==== tb/host_link_model.sv ====
// Purpose: host end of the serial command link, one byte per strobe
// Assumes: bytes change just after a rising edge, back to back
// Notes: idle data shows the inverse of the last byte, never a stale copy
`timescale 1ns/1ps
module host_link_model (
    input wire logic clock_in,
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    output logic rx_break_out
);
    initial begin
        rx_byte_out = 8'h00;
        rx_valid_out = 1'b0;
        rx_break_out = 1'b0;
    end

    // ==========================================
    // frame sender
    // first count bytes of a nine-byte frame, address first
    task automatic send_frame(input logic [71:0] frame, input int count);
        for (int i = 0; i < count; i++) begin
            @(posedge clock_in);
            rx_byte_out <= frame[71 - 8 * i -: 8];
            rx_valid_out <= 1'b1;
        end
        @(posedge clock_in);
        rx_valid_out <= 1'b0;
        rx_byte_out <= ~rx_byte_out;
        // a short frame is abandoned with a break so the unit resynchronises
        if (count < 9) begin
            rx_break_out <= 1'b1;
            @(posedge clock_in);
            rx_break_out <= 1'b0;
        end
    endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the axis reference search block
// Assumes: short step period so every search ends within a few hundred cycles
// Notes: registers over APB, command frames through the host link model
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] UNIT = 8'h03;
    logic clock_in;
    logic arst_n_in;
    axis_ref_pkg::apb_req_t apb_q;
    axis_ref_pkg::apb_rsp_t apb_out;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_break;
    logic [5:0] ref_q, stop_l_q, stop_r_q, step_out, dir_out, mixed_decay_out;
    logic drv_en_q, odd_off_q, even_off_q, seg_dp_out, irq_out, err;
    logic [1:0] fault_q;
    logic [6:0] seg_out;
    logic [31:0] rd;
    logic [71:0] fr;
    int errors, comparisons, snap, n;
    int steps [6];

    axis_reference_search #(.STEP_CYCLES(2)) axis_reference_search_inst (.clock_in(clock_in),
        .arst_n_in(arst_n_in), .apb_in(apb_q), .apb_out(apb_out), .rx_byte_in(rx_byte),
        .rx_valid_in(rx_valid), .rx_break_in(rx_break), .unit_addr_in(UNIT), .ref_in(ref_q),
        .stop_left_in(stop_l_q), .stop_right_in(stop_r_q), .drv_enable_in(drv_en_q),
        .decay_off_odd_group_in(odd_off_q), .decay_off_even_group_in(even_off_q),
        .fault_code_in(fault_q), .step_out(step_out), .dir_out(dir_out),
        .mixed_decay_out(mixed_decay_out), .seg_out(seg_out), .seg_dp_out(seg_dp_out), .irq_out(irq_out));
    host_link_model host_link_model_inst (.clock_in(clock_in), .rx_byte_out(rx_byte),
        .rx_valid_out(rx_valid), .rx_break_out(rx_break));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // non-blocking so a snapshot taken at an edge never races the count
    always @(posedge clock_in) begin
        for (int i = 0; i < 6; i++) begin
            if (step_out[i] === 1'b1) steps[i] <= steps[i] + 1;
        end
    end

    // ==========================================
    // shared tasks
    task automatic stop_test();
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int t;
        t = 0;
        @(posedge clock_in);
        apb_q <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge clock_in);
        apb_q.penable <= 1'b1;
        do begin
            @(posedge clock_in);
            t++;
        end while (apb_out.pready !== 1'b1 && t < 50);
        chk("pready", 32'h1, 32'(apb_out.pready));
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        apb_q.psel <= 1'b0;
        apb_q.penable <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    task automatic wait_done(input int ax);
        int k;
        k = 0;
        do begin
            apb(1'b0, axis_ref_pkg::ADDR_STATE, 32'h0000_0000);
            k++;
        end while (rd[ax] === 1'b1 && k < 200);
        chk("search_end", 32'h0, 32'(rd[ax]));
    endtask

    function automatic logic [71:0] frm(input logic [7:0] cmd, input logic [7:0] ax, input logic [23:0] len,
            input logic [7:0] p5, input logic [7:0] p6);
        return {UNIT, cmd, ax, len[7:0], len[15:8], len[23:16], 8'h00, p5, p6};
    endfunction

    task automatic load(input logic [7:0] ax, input logic [23:0] len, input logic [7:0] p5, input logic [7:0] p6);
        host_link_model_inst.send_frame(frm(axis_ref_pkg::CMD_SET_PARAMS, ax, len, p5, p6), 9);
        repeat (2) @(posedge clock_in);
    endtask

    task automatic start(input logic [7:0] ax);
        host_link_model_inst.send_frame(frm(axis_ref_pkg::CMD_BEGIN_HOMING, ax, 24'h00_0000, 8'h00, 8'h00), 9);
        repeat (2) @(posedge clock_in);
    endtask

    initial begin
        repeat (30000) @(posedge clock_in);
        errors++;
        stop_test();
    end

    // ==========================================
    // main sequence
    initial begin
        arst_n_in = 1'b0;
        apb_q = '0;
        ref_q = 6'h00;
        stop_l_q = 6'h00;
        stop_r_q = 6'h00;
        drv_en_q = 1'b1;
        odd_off_q = 1'b0;
        even_off_q = 1'b0;
        fault_q = 2'h0;
        repeat (3) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        chk("seg_zero", 32'h0000_003f, 32'(seg_out));
        chk("decay_all", 32'h0000_003f, 32'(mixed_decay_out));
        for (int i = 1; i < 4; i++) begin
            odd_off_q <= i[0];
            even_off_q <= i[1];
            fault_q <= 2'(i);
            repeat (3) @(posedge clock_in);
            chk("decay", 32'({3{~i[1], ~i[0]}}), 32'(mixed_decay_out));
            chk("fault_glyph", (i == 1) ? 32'h7f : (i == 2) ? 32'h39 : 32'h71, 32'(seg_out));
        end
        odd_off_q <= 1'b0;
        even_off_q <= 1'b0;
        fault_q <= 2'h0;
        apb(1'b1, axis_ref_pkg::ADDR_MASK, 32'h0000_0001);
        rchk("mask", axis_ref_pkg::ADDR_MASK, 32'h0000_0001);
        rchk("rotate_rst", axis_ref_pkg::ADDR_ROTATE, 32'h0000_0000);
        apb(1'b0, 12'h0fc, 32'h0000_0000);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rd);
        // electrical search leftward on axis 0
        load(8'h00, 24'h00_0010, 8'h10, 8'h00);
        rchk("no_start", axis_ref_pkg::ADDR_STATE, 32'h0000_0000);
        start(8'h00);
        chk("dir0", 32'h0, 32'(dir_out[0]));
        chk("seg_one", 32'h06, 32'(seg_out));
        repeat (10) @(posedge clock_in);
        ref_q[0] <= 1'b1;
        wait_done(0);
        rchk("state0", axis_ref_pkg::ADDR_STATE, 32'h0000_0100);
        rchk("pos0", axis_ref_pkg::ADDR_POS, 32'h0000_0000);
        chk("dp", 32'h1, 32'(seg_dp_out));
        chk("irq_set", 32'h1, 32'(irq_out));
        rchk("status0", axis_ref_pkg::ADDR_STATUS, 32'h0000_0001);
        repeat (2) @(posedge clock_in);
        chk("irq_clr", 32'h0, 32'(irq_out));
        // stopper search rightward on axis 1: five quarters of 8
        load(8'h01, 24'h00_0008, 8'h00, 8'h04);
        snap = steps[1];
        start(8'h01);
        chk("dir1", 32'h1, 32'(dir_out[1]));
        wait_done(1);
        repeat (4) @(posedge clock_in);
        chk("mech_steps", 32'd10, 32'(steps[1] - snap));
        chk("irq_masked", 32'h0, 32'(irq_out));
        rchk("status1", axis_ref_pkg::ADDR_STATUS, 32'h0000_0002);
        // axis 2: left switch ignored while moving right, right switch stops
        load(8'h02, 24'h00_03e8, 8'h00, 8'h00);
        snap = steps[2];
        start(8'h02);
        stop_l_q[2] <= 1'b1;
        repeat (40) @(posedge clock_in);
        rchk("left_ignored", axis_ref_pkg::ADDR_STATE, 32'h0000_0304);
        stop_r_q[2] <= 1'b1;
        wait_done(2);
        n = steps[2] - snap;
        repeat (10) @(posedge clock_in);
        chk("no_more_steps", 32'(n), 32'(steps[2] - snap));
        rchk("status2", axis_ref_pkg::ADDR_STATUS, 32'h0000_0100);
        rchk("pos2", axis_ref_pkg::ADDR_POS + 12'h008, 32'(n));
        rchk("full2", axis_ref_pkg::ADDR_FULL + 12'h008, 32'(n >> 4));
        stop_l_q[2] <= 1'b0;
        stop_r_q[2] <= 1'b0;
        // axis 3: normally closed reference also serving as left stop
        ref_q[3] <= 1'b1;
        load(8'h03, 24'h00_03e8, 8'h50, 8'h44);
        start(8'h03);
        repeat (20) @(posedge clock_in);
        rchk("nc_idle", axis_ref_pkg::ADDR_STATE, 32'h0000_0308);
        ref_q[3] <= 1'b0;
        wait_done(3);
        rchk("status3", axis_ref_pkg::ADDR_STATUS, 32'h0000_0200);
        // axis 4: foreign address and broken frame refused, then freeze
        load(8'h04, 24'h00_03e8, 8'h00, 8'h00);
        fr = frm(axis_ref_pkg::CMD_BEGIN_HOMING, 8'h04, 24'h00_0000, 8'h00, 8'h00);
        host_link_model_inst.send_frame({~UNIT, fr[63:0]}, 9);
        host_link_model_inst.send_frame(fr, 5);
        repeat (2) @(posedge clock_in);
        rchk("refused", axis_ref_pkg::ADDR_STATE, 32'h0000_0300);
        start(8'h04);
        drv_en_q <= 1'b0;
        repeat (3) @(posedge clock_in);
        snap = steps[4];
        repeat (20) @(posedge clock_in);
        chk("frozen", 32'(snap), 32'(steps[4]));
        drv_en_q <= 1'b1;
        rchk("kept", axis_ref_pkg::ADDR_STATE, 32'h0000_0310);
        ref_q[4] <= 1'b1;
        wait_done(4);
        rchk("status4", axis_ref_pkg::ADDR_STATUS, 32'h0000_0010);
        // axis 5: rotating, length 4, position wraps while moving right
        apb(1'b1, axis_ref_pkg::ADDR_ROTATE, 32'h0000_0020);
        rchk("rotate", axis_ref_pkg::ADDR_ROTATE, 32'h0000_0020);
        load(8'h05, 24'h00_0004, 8'h00, 8'h00);
        snap = steps[5];
        start(8'h05);
        repeat (30) @(posedge clock_in);
        stop_r_q[5] <= 1'b1;
        wait_done(5);
        repeat (4) @(posedge clock_in);
        n = steps[5] - snap;
        rchk("wrap", axis_ref_pkg::ADDR_POS + 12'h014, 32'(n % 4));
        rchk("final", axis_ref_pkg::ADDR_STATE, 32'h0000_1300);
        stop_test();
    end
endmodule
